// ==== cim_map.svh ====
// Register offsets, field positions, reset values and timing counts of the contact input monitor
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH

// Register byte offsets
`define CIM_CFG_OFS 12'h000
`define CIM_RDLY_OFS 12'h004
`define CIM_OFFDET_OFS 12'h008
`define CIM_STAT_OFS 12'h00c
`define CIM_IRQ_STAT_OFS 12'h010
`define CIM_IRQ_CLR_OFS 12'h014
`define CIM_IRQ_EN_OFS 12'h018
`define CIM_CMD_OFS 12'h01c

// Configuration register field positions
`define CIM_CFG_IN1_LSB 0
`define CIM_CFG_IN2_LSB 3
`define CIM_CFG_MODE_LSB 6
`define CIM_CFG_ACT_LSB 9
`define CIM_CFG_OUT1_LSB 11
`define CIM_CFG_OUT2_LSB 13
`define CIM_CFG_OUT3_LSB 15
`define CIM_CFG_NC_LSB 17
`define CIM_CFG_W 20

// Configuration reset value: input 1 level run, input 2 unused, local mode,
// stop on alarm, outputs run / remote / alarm, only output 3 normally closed
`define CIM_CFG_RST 20'h9c801

// Command register bits
`define CIM_CMD_START 0
`define CIM_CMD_STOP 1
`define CIM_CMD_ALM_CLR 2

// Interrupt event bits
`define CIM_EV_ALARM 0
`define CIM_EV_START 1
`define CIM_EV_STOP 2
`define CIM_EV_W 3

// Timer widths and reset values, in milliseconds
`define CIM_MS_W 16
`define CIM_RDLY_RST 16'h0000
`define CIM_OFFDET_RST 16'h0000

// Timebase
`define CIM_CLK_HZ 25000000
`define CIM_TICK_MS 1
`define CIM_TICK_CYCLES ((`CIM_CLK_HZ / 1000) * `CIM_TICK_MS)

`endif

// ==== cim_pkg.sv ====
// Types shared by the contact input monitor
package cim_pkg;

   // Function given to one contact input
   typedef enum logic [2:0] {
      CIM_IN_OFF = 3'h0,
      CIM_IN_RUN_LEVEL = 3'h1,
      CIM_IN_RUN_TOGGLE = 3'h2,
      CIM_IN_SW_NO = 3'h3,
      CIM_IN_SW_NC = 3'h4,
      CIM_IN_RMT_LEVEL = 3'h5,
      CIM_IN_RMT_TOGGLE = 3'h6
   } cim_in_func_t;

   // Communication mode
   typedef enum logic [2:0] {
      CIM_MODE_LOCAL = 3'h0,
      CIM_MODE_DIO = 3'h1,
      CIM_MODE_MODBUS = 3'h2,
      CIM_MODE_PROTO1 = 3'h3,
      CIM_MODE_PROTO2 = 3'h4
   } cim_mode_t;

   // Reaction to a detection alarm
   typedef enum logic [1:0] {
      CIM_ACT_STOP = 2'h0,
      CIM_ACT_CONTINUE = 2'h1,
      CIM_ACT_DISABLED = 2'h2
   } cim_alarm_act_t;

   // Condition reported on a contact output
   typedef enum logic [1:0] {
      CIM_OUT_OFF = 2'h0,
      CIM_OUT_RUN = 2'h1,
      CIM_OUT_REMOTE = 2'h2,
      CIM_OUT_ALARM = 2'h3
   } cim_out_func_t;

   // Operation state, Gray coded along stopped, delay, monitoring
   typedef enum logic [1:0] {
      CIM_STOPPED = 2'b00,
      CIM_READ_DELAY = 2'b01,
      CIM_MONITOR = 2'b11
   } cim_run_state_t;

endpackage : cim_pkg

// ==== cim_ms_timer.sv ====
// Millisecond timer that reports when a run has lasted a set number of ticks
`timescale 1ns/1ps
`default_nettype none

module cim_ms_timer
   import cim_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic tick, // One-cycle millisecond pulse
   input wire logic run, // Count while high, restart from zero when low
   input wire logic [WIDTH-1:0] limit, // Milliseconds to reach
   output logic done // High while run has lasted limit ticks
);

   logic [WIDTH-1:0] count; // Elapsed ticks, saturates at limit

   // Count ticks while run holds; any drop of run restarts from zero
   always_ff @(posedge clk)
   begin
      if (sys_rst || !run)
      begin
         count <= '0;
      end
      else if (tick && (count < limit))
      begin
         count <= count + 1'b1;
      end
   end

   // A zero limit expires at once
   assign done = run && (count >= limit);

endmodule : cim_ms_timer

`default_nettype wire

// ==== cim_top.sv ====
// Contact input run control, external switch supervision and contact outputs with APB registers
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module cim_top
   import cim_pkg::*;
#(
   parameter int TICK_CYCLES = `CIM_TICK_CYCLES, // Clock cycles per millisecond
   parameter int MS_W = `CIM_MS_W // Width of the millisecond settings
)
(
   input wire logic clk, // System clock, 25 MHz
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   input wire logic [1:0] contact_in, // Contact inputs, high when closed
   output logic [2:0] contact_out, // Contact outputs, high when closed
   output logic irq // Interrupt, high while an enabled event is pending
);

   // Register state
   logic [`CIM_CFG_W-1:0] cfg; // Functions, mode, alarm action, outputs
   logic [MS_W-1:0] read_delay_ms; // Reading delay setting
   logic [MS_W-1:0] off_detect_ms; // OFF detection setting
   logic [`CIM_EV_W-1:0] irq_status; // Sticky events
   logic [`CIM_EV_W-1:0] irq_enable; // Event mask

   // Decoded configuration
   cim_in_func_t in_func [2]; // Function of each contact input
   cim_mode_t mode; // Communication mode
   cim_alarm_act_t alarm_act; // Reaction to a detection alarm
   cim_out_func_t out_func [3]; // Condition on each contact output
   logic [2:0] out_nc; // Output type, high for normally closed

   // Bus strobes
   logic wr_en; // Write takes effect this edge
   logic rd_setup; // Read setup phase, data is captured
   logic addr_ok; // Address is mapped
   logic cmd_start; // Software start pulse
   logic cmd_stop; // Software stop pulse
   logic cmd_alm_clr; // Software alarm clear pulse

   // Contact input state
   logic [1:0] in_prev; // Input level one cycle earlier
   logic [1:0] released; // Contact went from closed to open
   logic [1:0] is_run_lvl; // Input is a level run input
   logic [1:0] is_run_tgl; // Input is a toggle run input
   logic [1:0] is_rmt_lvl; // Input is a level remote input
   logic [1:0] is_rmt_tgl; // Input is a toggle remote input
   logic [1:0] is_sw; // Input supervises an external switch
   logic [1:0] sw_healthy; // Switch is in its healthy state
   logic [1:0] sw_allowed; // Switch may be supervised in this mode
   logic [1:0] sw_fault; // Switch stayed out of its healthy state for the OFF time

   // Run control
   cim_run_state_t state; // Operation state
   cim_run_state_t next_state; // Next operation state
   logic remote_toggle; // Remote state held by a toggle input
   logic remote_state; // Device is in contact remote state
   logic has_run_input; // Some input carries a run function
   logic contact_ctrl; // Contacts steer run and stop
   logic start_req; // Request to start this cycle
   logic stop_req; // Request to stop this cycle
   logic running; // Device operates
   logic delay_done; // Reading delay has elapsed
   logic fault_any; // Some supervised switch stayed out of its healthy state for the OFF time
   logic alarm; // Detection alarm latched
   logic alarm_set; // Detection alarm raised this cycle
   logic trip; // Alarm forces a stop this cycle
   logic [`CIM_EV_W-1:0] events; // Event pulses for the status register

   // Millisecond timebase
   logic [$clog2(TICK_CYCLES)-1:0] tick_cnt; // Cycles within the millisecond
   logic tick; // One-cycle millisecond pulse

   // Field decode of the configuration register
   always_comb
   begin
      in_func[0] = cim_in_func_t'(cfg[`CIM_CFG_IN1_LSB +: 3]);
      in_func[1] = cim_in_func_t'(cfg[`CIM_CFG_IN2_LSB +: 3]);
      mode = cim_mode_t'(cfg[`CIM_CFG_MODE_LSB +: 3]);
      alarm_act = cim_alarm_act_t'(cfg[`CIM_CFG_ACT_LSB +: 2]);
      out_func[0] = cim_out_func_t'(cfg[`CIM_CFG_OUT1_LSB +: 2]);
      out_func[1] = cim_out_func_t'(cfg[`CIM_CFG_OUT2_LSB +: 2]);
      out_func[2] = cim_out_func_t'(cfg[`CIM_CFG_OUT3_LSB +: 2]);
      out_nc = cfg[`CIM_CFG_NC_LSB +: 3];
   end

   // APB decode; the slave never waits, so pready is always high
   assign pready = 1'b1;
   assign addr_ok = (paddr == `CIM_CFG_OFS) || (paddr == `CIM_RDLY_OFS) || (paddr == `CIM_OFFDET_OFS)
                    || (paddr == `CIM_STAT_OFS) || (paddr == `CIM_IRQ_STAT_OFS) || (paddr == `CIM_IRQ_CLR_OFS)
                    || (paddr == `CIM_IRQ_EN_OFS) || (paddr == `CIM_CMD_OFS);
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;
   assign cmd_start = wr_en && (paddr == `CIM_CMD_OFS) && pwdata[`CIM_CMD_START];
   assign cmd_stop = wr_en && (paddr == `CIM_CMD_OFS) && pwdata[`CIM_CMD_STOP];
   assign cmd_alm_clr = wr_en && (paddr == `CIM_CMD_OFS) && pwdata[`CIM_CMD_ALM_CLR];

   // Writable settings; defaults give the factory assignment of inputs and outputs
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cfg <= `CIM_CFG_RST;
         read_delay_ms <= `CIM_RDLY_RST;
         off_detect_ms <= `CIM_OFFDET_RST;
         irq_enable <= '0;
      end
      else if (wr_en)
      begin
         case (paddr)
            `CIM_CFG_OFS: cfg <= pwdata[`CIM_CFG_W-1:0];
            `CIM_RDLY_OFS: read_delay_ms <= pwdata[MS_W-1:0];
            `CIM_OFFDET_OFS: off_detect_ms <= pwdata[MS_W-1:0];
            `CIM_IRQ_EN_OFS: irq_enable <= pwdata[`CIM_EV_W-1:0];
            default: ; // Other offsets hold no setting
         endcase
      end
   end

   // Read data is captured in the setup phase so it stands from a flip-flop in the access phase
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         prdata <= '0;
      end
      else if (rd_setup)
      begin
         case (paddr)
            `CIM_CFG_OFS: prdata <= {12'h000, cfg};
            `CIM_RDLY_OFS: prdata <= {16'h0000, read_delay_ms};
            `CIM_OFFDET_OFS: prdata <= {16'h0000, off_detect_ms};
            `CIM_STAT_OFS: prdata <= {21'h000000, contact_out, sw_fault, contact_in,
                                      alarm, remote_state, state};
            `CIM_IRQ_STAT_OFS: prdata <= {29'h00000000, irq_status};
            `CIM_IRQ_EN_OFS: prdata <= {29'h00000000, irq_enable};
            default: prdata <= '0; // Clear and command registers read as zero
         endcase
      end
   end

   // Millisecond tick shared by every timer
   always_ff @(posedge clk)
   begin
      if (sys_rst || tick)
      begin
         tick_cnt <= '0;
      end
      else
      begin
         tick_cnt <= tick_cnt + 1'b1;
      end
   end
   assign tick = (tick_cnt == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

   // Previous input levels; inputs are already synchronous to clk
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         in_prev <= '0;
      end
      else
      begin
         in_prev <= contact_in;
      end
   end

   // Per-input decode and switch supervision
   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_in
         // Toggle forms act on the release, so a held contact does nothing until it opens
         assign released[i] = in_prev[i] && !contact_in[i];
         assign is_run_lvl[i] = (in_func[i] == CIM_IN_RUN_LEVEL);
         assign is_run_tgl[i] = (in_func[i] == CIM_IN_RUN_TOGGLE);
         // Only input 2 may carry the remote function
         assign is_rmt_lvl[i] = (i == 1) && (in_func[i] == CIM_IN_RMT_LEVEL);
         assign is_rmt_tgl[i] = (i == 1) && (in_func[i] == CIM_IN_RMT_TOGGLE);
         assign is_sw[i] = (in_func[i] == CIM_IN_SW_NO) || (in_func[i] == CIM_IN_SW_NC);
         // Open type is healthy when closed, closed type when open
         assign sw_healthy[i] = (in_func[i] == CIM_IN_SW_NO) ? contact_in[i] : !contact_in[i];
         // Switch 1 only in local, MODBUS and protocol 1; switch 2 everywhere
         assign sw_allowed[i] = (i == 1) || (mode == CIM_MODE_LOCAL) || (mode == CIM_MODE_MODBUS)
                                || (mode == CIM_MODE_PROTO1);

         // OFF detection restarts when the switch turns healthy or supervision ends
         cim_ms_timer #(.WIDTH(MS_W)) u_off_timer (
            .clk(clk),
            .sys_rst(sys_rst),
            .tick(tick),
            .run((state == CIM_MONITOR) && is_sw[i] && sw_allowed[i] && !sw_healthy[i]),
            .limit(off_detect_ms),
            .done(sw_fault[i])
         );
      end
   endgenerate

   // Reading delay counted from the start of operation
   cim_ms_timer #(.WIDTH(MS_W)) u_read_delay (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .run(state == CIM_READ_DELAY),
      .limit(read_delay_ms),
      .done(delay_done)
   );

   // Remote state held by a toggle remote input
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         remote_toggle <= 1'b0;
      end
      else if (is_rmt_tgl[1] && released[1])
      begin
         remote_toggle <= !remote_toggle;
      end
   end

   // Without a remote input, the DIO mode is taken as remote
   always_comb
   begin
      if (mode != CIM_MODE_DIO)
      begin
         remote_state = 1'b0;
      end
      else if (is_rmt_lvl[1])
      begin
         remote_state = contact_in[1];
      end
      else if (is_rmt_tgl[1])
      begin
         remote_state = remote_toggle;
      end
      else
      begin
         remote_state = 1'b1;
      end
   end

   // Contacts steer run only with a run function assigned
   assign has_run_input = |(is_run_lvl | is_run_tgl);
   assign contact_ctrl = remote_state && has_run_input;
   assign running = (state != CIM_STOPPED);

   // Start and stop requests from the contacts or from software
   always_comb
   begin
      start_req = 1'b0;
      stop_req = 1'b0;
      if (contact_ctrl)
      begin
         // Level input holds run for as long as it is closed
         start_req = |(is_run_lvl & contact_in);
         stop_req = |is_run_lvl && !(|(is_run_lvl & contact_in));
         // Toggle input flips the state on release
         if (|(is_run_tgl & released))
         begin
            start_req = !running;
            stop_req = running;
         end
      end
      else
      begin
         start_req = cmd_start;
         stop_req = cmd_stop;
      end
   end

   // Supervision only during monitoring; either switch suffices
   assign fault_any = |sw_fault;
   assign alarm_set = (state == CIM_MONITOR) && fault_any && (alarm_act != CIM_ACT_DISABLED);
   assign trip = alarm_set && (alarm_act == CIM_ACT_STOP);

   // Operation state machine; a latched stop alarm blocks restart until cleared
   always_comb
   begin
      next_state = state;
      case (state)
         CIM_STOPPED:
         begin
            if (start_req && !(alarm && (alarm_act == CIM_ACT_STOP)))
            begin
               next_state = CIM_READ_DELAY;
            end
         end
         CIM_READ_DELAY:
         begin
            if (stop_req)
            begin
               next_state = CIM_STOPPED;
            end
            else if (delay_done)
            begin
               next_state = CIM_MONITOR;
            end
         end
         CIM_MONITOR:
         begin
            if (stop_req || trip)
            begin
               next_state = CIM_STOPPED;
            end
         end
         default: next_state = CIM_STOPPED;
      endcase
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= CIM_STOPPED;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Detection alarm latch; a new alarm wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         alarm <= 1'b0;
      end
      else if (alarm_set)
      begin
         alarm <= 1'b1;
      end
      else if (cmd_alm_clr)
      begin
         alarm <= 1'b0;
      end
   end

   // Event pulses
   assign events[`CIM_EV_ALARM] = alarm_set && !alarm;
   assign events[`CIM_EV_START] = (state == CIM_STOPPED) && (next_state != CIM_STOPPED);
   assign events[`CIM_EV_STOP] = (state != CIM_STOPPED) && (next_state == CIM_STOPPED);

   // Sticky event bits; setting wins over clearing
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         irq_status <= '0;
      end
      else if (wr_en && (paddr == `CIM_IRQ_CLR_OFS))
      begin
         irq_status <= (irq_status & ~pwdata[`CIM_EV_W-1:0]) | events;
      end
      else
      begin
         irq_status <= irq_status | events;
      end
   end
   assign irq = |(irq_status & irq_enable);

   // Contact outputs; an open type closes on its condition, a closed type opens
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         contact_out <= '0;
      end
      else
      begin
         for (int k = 0; k < 3; k++)
         begin
            case (out_func[k])
               CIM_OUT_RUN: contact_out[k] <= running ^ out_nc[k];
               CIM_OUT_REMOTE: contact_out[k] <= remote_state ^ out_nc[k];
               CIM_OUT_ALARM: contact_out[k] <= alarm ^ out_nc[k];
               default: contact_out[k] <= out_nc[k]; // No signal: resting contact state
            endcase
         end
      end
   end

endmodule : cim_top

`default_nettype wire

// ==== cim_top_properties.sv ====
// Checks on the contact monitor ports
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module cim_top_checker
   import cim_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic pready, // APB ready
   input wire logic [1:0] contact_in, // Contact inputs
   input wire logic [2:0] contact_out // Contact outputs
);
   logic [19:0] cfg; // Shadow of the configuration register
   logic run_ok; // Contacts steer run
   logic out1_run; // Output 1 reports running, normally open
   logic out2_rmt; // Output 2 reports remote, normally open
   logic out3_alm; // Output 3 reports alarm, normally closed

   // Shadow of configuration writes
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cfg <= `CIM_CFG_RST; // Factory defaults
      else if (psel && penable && pready && pwrite && paddr == `CIM_CFG_OFS)
         cfg <= pwdata[19:0];
   end

   // Field decodes
   assign run_ok = cfg[8:6] == CIM_MODE_DIO && (cfg[5:3] == CIM_IN_OFF || cfg[5:3] == CIM_IN_SW_NO
      || cfg[5:3] == CIM_IN_SW_NC);
   assign out1_run = cfg[12:11] == CIM_OUT_RUN && !cfg[17];
   assign out2_rmt = cfg[14:13] == CIM_OUT_REMOTE && !cfg[18];
   assign out3_alm = cfg[16:15] == CIM_OUT_ALARM && cfg[19];

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_out_reset: assert property ($fell(sys_rst) |-> ##1 contact_out == 3'b100)
      else $error("contact outputs not at rest after reset");
   chk_run_level_stop: assert property ((run_ok && out1_run && cfg[2:0] == CIM_IN_RUN_LEVEL && !contact_in[0])[*2]
      |-> ##[0:2] !contact_out[0])
      else $error("level run input open but still running");
   chk_run_toggle: assert property (run_ok && out1_run && cfg[2:0] == CIM_IN_RUN_TOGGLE && $fell(contact_in[0])
      |-> ##2 contact_out[0] != $past(contact_out[0], 2))
      else $error("toggle run release did not flip running");
   chk_rmt_level: assert property ((cfg[8:6] == CIM_MODE_DIO && cfg[5:3] == CIM_IN_RMT_LEVEL && out2_rmt
      && $stable(contact_in[1]))[*4] |-> contact_out[1] == contact_in[1])
      else $error("remote output does not follow level remote input");
   chk_rmt_toggle: assert property (cfg[8:6] == CIM_MODE_DIO && cfg[5:3] == CIM_IN_RMT_TOGGLE && out2_rmt
      && $fell(contact_in[1]) |-> ##2 contact_out[1] != $past(contact_out[1], 2))
      else $error("toggle remote release did not flip remote");
   chk_alarm_stops: assert property (cfg[10:9] == CIM_ACT_STOP && out1_run && out3_alm && $fell(contact_out[2])
      |-> !contact_out[0])
      else $error("detection alarm did not stop operation");
   chk_alarm_running: assert property (out1_run && out3_alm && $fell(contact_out[2])
      |-> $past(contact_out[0]))
      else $error("detection alarm raised while stopped");
   chk_out_off_level: assert property ((cfg[12:11] == CIM_OUT_OFF && $stable(cfg[17]))[*3]
      |-> contact_out[0] == cfg[17])
      else $error("unused output not at its rest level");
endmodule : cim_top_checker

bind cim_top cim_top_checker i_cim_top_checker (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .contact_in(contact_in),
   .contact_out(contact_out));
`default_nettype wire

// ==== cim_contact_model.sv ====
// Customer switches and contact-driving controller on the contact inputs
`timescale 1ns/1ps
`default_nettype none

module cim_contact_model
#(
   parameter int HOLD_CYC = 3000 // Cycles in 300 ms of press
)
(
   input wire logic clk, // System clock
   output logic [1:0] contact_in // Contact levels, high when closed
);
   // Dry contacts start open
   initial contact_in = 2'b00;

   // Set one contact after an edge
   task automatic set_contact(input int i, input logic v);
      @(posedge clk);
      contact_in[i] <= v;
   endtask : set_contact

   // Press held 300 ms plus a random extra
   task automatic press(input int i);
      set_contact(i, 1'b1);
      repeat (HOLD_CYC + $urandom_range(20, 0)) @(posedge clk);
      contact_in[i] <= 1'b0;
   endtask : press
endmodule : cim_contact_model
`default_nettype wire

// ==== tb_cim_top.sv ====
// Self-checking bench of the contact input monitor
`timescale 1ns/1ps
`default_nettype none
`include "cim_map.svh"

module tb_cim_top
   import cim_pkg::*;
();
   localparam int TK = 10; // Short millisecond keeps the run brief
   localparam logic [31:0] ALL = 32'hffffffff; // Whole-word mask
   typedef struct {logic [31:0] v; logic [31:0] m; logic e;} cim_note_t; // Expected read
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq;
   logic [1:0] contact_in;
   logic [2:0] contact_out;
   int errors = 0, samples_checked = 0;
   cim_note_t exp_q[$]; // Reads still to be answered, oldest first
   cim_note_t note; // Note being compared

   initial forever #20 clk = ~clk;

   cim_top #(.TICK_CYCLES(TK)) i_cim_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .contact_in(contact_in), .contact_out(contact_out), .irq(irq));
   cim_contact_model #(.HOLD_CYC(300 * TK)) i_cim_contact_model (.clk(clk), .contact_in(contact_in));

   task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : compare

   task automatic results();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   // Configuration word, default outputs
   function automatic logic [31:0] cfgv(input logic [2:0] i1, i2, md, input logic [1:0] ac);
      return {12'h0, 3'b100, 2'h3, 2'h2, 2'h1, ac, md, i2, i1};
   endfunction : cfgv

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (pready !== 1'b1)
      begin
         errors++;
         results();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m, input logic e = 1'b0);
      exp_q.push_back('{v & m, m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Bounded wait for an output level
   task automatic wait_out(input int i, input logic v);
      int n = 0;
      while (contact_out[i] !== v && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      compare("contact_out", {31'h0, v}, {31'h0, contact_out[i]});
      if (n == 2000)
         results();
   endtask : wait_out

   task automatic set_in(input int i, input logic v);
      i_cim_contact_model.set_contact(i, v);
   endtask : set_in

   // Software run with switch 1 at a level
   task automatic try(input logic [31:0] c, input logic ci, input logic [31:0] e);
      wr(`CIM_CFG_OFS, c);
      set_in(0, ci);
      wr(`CIM_CMD_OFS, 32'h1);
      repeat (10) @(negedge clk);
      rd(`CIM_STAT_OFS, e, 32'hb);
      repeat (2) wr(`CIM_CMD_OFS, 32'h6);
   endtask : try

   // Read answers matched to the oldest note
   always @(posedge clk)
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      begin
         note = exp_q.pop_front();
         compare("prdata", note.v, prdata & note.m);
         compare("pslverr", {31'h0, note.e}, {31'h0, pslverr});
      end

   // Main sequence
   initial
   begin
      int rdly;
      void'($urandom(49));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`CIM_CFG_OFS, cfgv(1, 0, 0, 0), ALL);
      rd(`CIM_RDLY_OFS, 32'h0, ALL);
      rd(`CIM_OFFDET_OFS, 32'h0, ALL);
      rd(`CIM_IRQ_EN_OFS, 32'h0, ALL);
      rd(12'h020, 32'h0, ALL, 1'b1);
      compare("contact_out", 32'h4, {29'h0, contact_out});
      // Supervised run, random reading delay
      rdly = $urandom_range(5, 2);
      wr(`CIM_IRQ_EN_OFS, 32'h7);
      wr(`CIM_RDLY_OFS, rdly);
      wr(`CIM_OFFDET_OFS, 32'h3);
      set_in(1, 1'b1);
      wr(`CIM_CFG_OFS, cfgv(1, 3, 1, 0));
      wait_out(1, 1'b1);
      set_in(0, 1'b1);
      wait_out(0, 1'b1);
      rd(`CIM_STAT_OFS, 32'h1, 32'h3);
      repeat ((rdly + 1) * TK) @(negedge clk);
      rd(`CIM_STAT_OFS, 32'h3, 32'h3);
      // Short opening, no alarm
      set_in(1, 1'b0);
      repeat (2 * TK - 5) @(negedge clk);
      set_in(1, 1'b1);
      repeat (5 * TK) @(negedge clk);
      rd(`CIM_IRQ_STAT_OFS, 32'h2, 32'h7);
      set_in(1, 1'b0);
      wait_out(2, 1'b0);
      compare("contact_out", 32'h2, {29'h0, contact_out});
      compare("irq", 32'h1, {31'h0, irq});
      rd(`CIM_STAT_OFS, 32'h8, 32'hb);
      wr(`CIM_IRQ_EN_OFS, 32'h0);
      compare("irq", 32'h0, {31'h0, irq});
      wr(`CIM_IRQ_CLR_OFS, 32'h7);
      wr(`CIM_IRQ_EN_OFS, 32'h7);
      compare("irq", 32'h0, {31'h0, irq});
      // Alarm clear, restart, stop ends supervision
      set_in(1, 1'b1);
      wr(`CIM_CMD_OFS, 32'h4);
      wait_out(0, 1'b1);
      set_in(0, 1'b0);
      wait_out(0, 1'b0);
      set_in(1, 1'b0);
      repeat (10 * TK) @(negedge clk);
      rd(`CIM_IRQ_STAT_OFS, 32'h6, 32'h7);
      compare("irq", 32'h1, {31'h0, irq});
      wr(`CIM_IRQ_CLR_OFS, 32'h7);
      wr(`CIM_OFFDET_OFS, 32'h0);
      wr(`CIM_RDLY_OFS, 32'h0);
      // Switch 1 in every mode and polarity
      for (int m = 0; m < 5; m++)
         for (int p = 3; p < 5; p++)
            for (int h = 0; h < 2; h++)
               try(cfgv(p[2:0], 0, m[2:0], 0), (p == 4) ^ h[0], (m != 1 && m != 4 && h == 0) ? 32'h8 : 32'h3);
      for (int a = 1; a < 3; a++)
         try(cfgv(3, 0, 0, a[1:0]), 1'b0, (a == 1) ? 32'hb : 32'h3);
      // Toggle run and remote inputs, level remote input
      wr(`CIM_CFG_OFS, cfgv(2, 0, 1, 0));
      i_cim_contact_model.press(0);
      wait_out(0, 1'b1);
      i_cim_contact_model.press(0);
      wait_out(0, 1'b0);
      wr(`CIM_CFG_OFS, cfgv(1, 5, 1, 0));
      wait_out(1, 1'b0);
      set_in(1, 1'b1);
      wait_out(1, 1'b1);
      set_in(1, 1'b0);
      wr(`CIM_CFG_OFS, cfgv(1, 6, 1, 0));
      i_cim_contact_model.press(1);
      wait_out(1, 1'b1);
      i_cim_contact_model.press(1);
      wait_out(1, 1'b0);
      // No run function; output 1 unused, normally closed
      wr(`CIM_CFG_OFS, (cfgv(0, 0, 1, 0) & 32'hffffe7ff) | 32'h20000);
      set_in(0, 1'b1);
      repeat (20) @(negedge clk);
      rd(`CIM_STAT_OFS, 32'h0, 32'h3);
      compare("contact_out", 32'h1, {31'h0, contact_out[0]});
      results();
   end
endmodule : tb_cim_top
`default_nettype wire
